/* hdl/ivp_top.sv */
// Prioritised interrupt vectoring with APB register access
//
// Summary of operation
// - Higher priority level always wins over every lower level.
// - Within one level the smallest vector number wins.
// - Fetch address is programmable vector base plus entry offset.
// - Each entry is two words; offset is twice the vector number.
// - Base value 0x0200 overlays entries 0 and 1 on reset addresses.
// - Core exceptions sit at fixed level 3 on vectors 2 to 5.
// - Debug sources on vectors 6,7,9,10,11 take levels 1 to 3.
// - External request and peripherals take levels 0 to 2.
// - Supply monitor on vector 20, clock synthesiser on vector 21.
// - Flash controller requests on vectors 22, 23 and 24.
// - CAN bus-off 26, error 27, wake-up 28, buffers 29.
// - Second SPI on vectors 38 and 39, first SPI on 40 and 41.
// - Second serial on 42,43,45,46; first serial on 68,69,71,72.
// - Quadrature decoder home/watchdog on 49, index on 50.
// - Converter complete on 74, zero crossing or limit on 76.
`timescale 1ns/1ps

module ivp_top
  import ivp_pkg::*;
#(
  parameter int P_ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  // APB slave
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [P_ADDR_W-1:0]       i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  // Core exception, debug, software and external request sources
  input  wire logic [3:0]                i_core_exc,
  input  wire logic [4:0]                i_debug_req,
  input  wire logic [3:0]                i_soft_irq,
  input  wire logic                      i_external_interrupt_request,
  // Peripheral sources
  input  wire logic                      i_supply_voltage_monitor,
  input  wire logic                      i_clock_synth,
  input  wire logic [2:0]                i_flash_controller,
  input  wire logic [3:0]                i_can_unit,
  input  wire logic                      i_port_three_pins,
  input  wire logic                      i_port_two_pins,
  input  wire logic                      i_port_one_pins,
  input  wire logic [1:0]                i_second_spi_unit,
  input  wire logic [1:0]                i_first_spi_unit,
  input  wire logic [3:0]                i_second_serial_unit,
  input  wire logic [3:0]                i_first_serial_unit,
  input  wire logic [1:0]                i_quadrature_decoder,
  input  wire logic [3:0]                i_timer_group_two,
  input  wire logic [3:0]                i_timer_group_one,
  input  wire logic [1:0]                i_converter_unit,
  input  wire logic [1:0]                i_pwm_unit,
  input  wire logic                      i_spare_req,
  // Core side
  input  wire logic                      i_core_ack,
  output logic                           o_irq_valid,
  output logic      [ivp_pkg::VEC_W-1:0] o_irq_vector,
  output logic      [2:0]                o_irq_rank,
  output logic      [ivp_pkg::FETCH_W-1:0] o_fetch_addr,
  output logic                           o_reset_overlay,
  // Interrupt to system
  output logic                           o_int
);
  import ivp_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  if (P_ADDR_W < 6 || P_ADDR_W > 32) begin : g_bad_addr
    $error("P_ADDR_W must lie between 6 and 32");
  end

  // ****************************************
  // Declarations
  // ****************************************
  localparam int PEND_W = 32 * 3;
  localparam int LVL_W  = 32 * LVL_REGS;

  logic [BASE_W-1:0]  vector_table_base_r;
  logic [31:0]        level_r [LVL_REGS];
  logic [STAT_W-1:0]  stat_r;
  logic [STAT_W-1:0]  mask_r;
  logic [STAT_W-1:0]  stat_set;
  logic [STAT_W-1:0]  stat_clr;
  logic [NUM_VEC-1:0] req_w;
  logic [PEND_W-1:0]  pend_w;
  logic [LVL_W-1:0]   prog_mask;
  logic [2:0]         rank_w [NUM_VEC];
  logic [2:0]         best_rank;
  logic [VEC_W-1:0]   best_vec;
  logic [FETCH_W-1:0] fetch_nxt;
  logic               acc_phase;
  logic               wr_fire;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic               lvl_hit;
  logic [7:0]         off;
  logic [7:0]         lvl_off;
  logic [2:0]         lvl_idx;

  // ****************************************
  // Geometry checks
  // ****************************************
  if (FETCH_W != BASE_W + BASE_SHIFT) begin : g_bad_fetch
    $error("FETCH_W must equal BASE_W plus BASE_SHIFT");
  end
  if (BASE_SHIFT < VEC_W + 1) begin : g_bad_shift
    $error("Entry offsets must fit below the shifted base");
  end
  if (NUM_VEC > 2 ** VEC_W) begin : g_bad_vec_w
    $error("NUM_VEC exceeds the vector number width");
  end
  if (NUM_VEC < 83) begin : g_bad_vec_n
    $error("Request map needs vectors up to 82");
  end
  if (NUM_VEC > PEND_W) begin : g_bad_pend
    $error("Pending words too few for NUM_VEC");
  end
  if (2 * NUM_VEC > LVL_W) begin : g_bad_lvl
    $error("Level registers too few for NUM_VEC");
  end
  if (LVL_REGS > 8) begin : g_bad_regs
    $error("Level register index is three bits wide");
  end
  if (OFF_LVL_E != OFF_LVL0 + 8'(4 * LVL_REGS)) begin : g_bad_lvl_end
    $error("Level window end disagrees with LVL_REGS");
  end
  if (STAT_ACK >= STAT_W || STAT_TOP >= STAT_W) begin : g_bad_stat
    $error("Status bit positions exceed STAT_W");
  end
  if (2 * FLD_PER_REG != 32) begin : g_bad_fld
    $error("Level fields must fill one 32-bit word");
  end

  // ****************************************
  // Request vector assembly
  // ****************************************
  always_comb begin
    req_w       = '0;
    req_w[5:2]  = i_core_exc;
    req_w[7:6]  = i_debug_req[1:0];
    req_w[11:9] = i_debug_req[4:2];
    req_w[16:14] = i_soft_irq[2:0];
    req_w[81]   = i_soft_irq[3];
    req_w[17]   = i_external_interrupt_request;
    req_w[20]   = i_supply_voltage_monitor;
    req_w[21]   = i_clock_synth;
    req_w[24:22] = i_flash_controller;
    req_w[29:26] = i_can_unit;
    req_w[33]   = i_port_three_pins;
    req_w[34]   = i_port_two_pins;
    req_w[35]   = i_port_one_pins;
    req_w[39:38] = i_second_spi_unit;
    req_w[41:40] = i_first_spi_unit;
    req_w[43:42] = i_second_serial_unit[1:0];
    req_w[46:45] = i_second_serial_unit[3:2];
    req_w[69:68] = i_first_serial_unit[1:0];
    req_w[72:71] = i_first_serial_unit[3:2];
    req_w[50:49] = i_quadrature_decoder;
    req_w[59:56] = i_timer_group_two;
    req_w[67:64] = i_timer_group_one;
    req_w[74]   = i_converter_unit[0];
    req_w[76]   = i_converter_unit[1];
    req_w[78]   = i_pwm_unit[0];
    req_w[80]   = i_pwm_unit[1];
    req_w[82]   = i_spare_req;
  end

  // ****************************************
  // Per-vector rank
  // ****************************************
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
    localparam ivp_kind_t KIND = ivp_vec_kind(v);
    logic [1:0] fld;
    logic [2:0] base_rank;

    assign fld = level_r[v / FLD_PER_REG][2 * (v % FLD_PER_REG) +: 2];

    if (KIND == KIND_P13) begin : g_p13
      assign base_rank = (fld == 2'h0) ? RANK_NONE
                                       : 3'(fld) + RANK_L0;
      assign prog_mask[2*v +: 2] = 2'h3;
    end else if (KIND == KIND_P02) begin : g_p02
      assign base_rank = (fld == 2'h0) ? RANK_NONE
                                       : 3'(fld) + RANK_LP;
      assign prog_mask[2*v +: 2] = 2'h3;
    end else begin : g_fixed
      assign prog_mask[2*v +: 2] = 2'h0;
      if (KIND == KIND_L3) begin : g_l3
        assign base_rank = RANK_L3;
      end else if (KIND == KIND_L2) begin : g_l2
        assign base_rank = RANK_L2;
      end else if (KIND == KIND_L1) begin : g_l1
        assign base_rank = RANK_L1;
      end else if (KIND == KIND_L0) begin : g_l0
        assign base_rank = RANK_L0;
      end else if (KIND == KIND_LP) begin : g_lp
        assign base_rank = RANK_LP;
      end else begin : g_rsvd
        assign base_rank = RANK_NONE;
      end
    end

    assign rank_w[v] = req_w[v] ? base_rank : RANK_NONE;
    assign pend_w[v] = req_w[v] && (base_rank != RANK_NONE);
  end

  assign pend_w[PEND_W-1:NUM_VEC]   = '0;
  assign prog_mask[LVL_W-1:2*NUM_VEC] = '0;

  // ****************************************
  // Winner selection
  // ****************************************
  // Scan from the top so that an equal rank at a lower vector replaces
  always_comb begin
    best_rank = RANK_NONE;
    best_vec  = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (rank_w[v] != RANK_NONE && rank_w[v] >= best_rank) begin
        best_rank = rank_w[v];
        best_vec  = VEC_W'(v);
      end
    end
  end

  // Two program words per entry, placed above the base
  assign fetch_nxt = {vector_table_base_r, {BASE_SHIFT{1'b0}}}
                   + {{(FETCH_W-VEC_W-1){1'b0}}, best_vec, 1'b0};

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq_valid  <= 1'b0;
      o_irq_vector <= '0;
      o_irq_rank   <= RANK_NONE;
      o_fetch_addr <= '0;
    end else begin
      o_irq_valid  <= (best_rank != RANK_NONE);
      o_irq_vector <= best_vec;
      o_irq_rank   <= best_rank;
      o_fetch_addr <= fetch_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_reset_overlay <= 1'b0;
    end else begin
      o_reset_overlay <= (vector_table_base_r == OVERLAY_BASE);
    end
  end

  // ****************************************
  // APB handshake and decode
  // ****************************************
  assign acc_phase = i_psel && i_penable;
  assign wr_fire   = acc_phase && o_pready && i_pwrite;
  assign off       = 8'(i_paddr);
  assign lvl_off   = off - OFF_LVL0;
  assign lvl_idx   = lvl_off[4:2];
  assign lvl_hit   = (off >= OFF_LVL0) && (off < OFF_LVL_E)
                   && (off[1:0] == 2'h0);

  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (P_ADDR_W > 8 && (i_paddr >> 8) != '0) begin
      rd_hit = 1'b0;
    end else if (lvl_hit) begin
      rd_data = level_r[lvl_idx] & prog_mask[32*lvl_idx +: 32];
    end else begin
      unique case (off)
        OFF_BASE:  rd_data = {{(32-BASE_W){1'b0}}, vector_table_base_r};
        OFF_PEND0: rd_data = pend_w[31:0];
        OFF_PEND1: rd_data = pend_w[63:32];
        OFF_PEND2: rd_data = pend_w[95:64];
        OFF_WIN:   rd_data = {21'h0, o_irq_valid, o_irq_rank,
                              o_irq_vector};
        OFF_STAT:  rd_data = {{(32-STAT_W){1'b0}}, stat_r};
        OFF_MASK:  rd_data = {{(32-STAT_W){1'b0}}, mask_r};
        default:   rd_hit  = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (acc_phase && !o_pready) begin
      o_pready  <= 1'b1;
      o_prdata  <= (rd_hit && !i_pwrite) ? rd_data : 32'h0;
      o_pslverr <= !rd_hit;
    end else begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      vector_table_base_r <= BASE_RST;
    end else if (wr_fire && rd_hit && off == OFF_BASE) begin
      vector_table_base_r <= i_pwdata[BASE_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < LVL_REGS; i++) begin
        level_r[i] <= '0;
      end
    end else if (wr_fire && rd_hit && lvl_hit) begin
      level_r[lvl_idx] <= i_pwdata & prog_mask[32*lvl_idx +: 32];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mask_r <= MASK_RST;
    end else if (wr_fire && rd_hit && off == OFF_MASK) begin
      mask_r <= i_pwdata[STAT_W-1:0];
    end
  end

  // ****************************************
  // Sticky status and interrupt
  // ****************************************
  always_comb begin
    stat_set           = '0;
    stat_set[STAT_ACK] = i_core_ack && o_irq_valid;
    stat_set[STAT_TOP] = (best_rank == RANK_L3) && (o_irq_rank != RANK_L3);
    stat_clr           = '0;
    if (wr_fire && rd_hit && off == OFF_STAT) begin
      stat_clr = i_pwdata[STAT_W-1:0];
    end
  end

  // Set beats a same-cycle clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_int <= 1'b0;
    end else begin
      o_int <= |(stat_r & mask_r);
    end
  end

endmodule : ivp_top

/* hdl/ivp_pkg.sv */
// Constants, types and vector table map of the interrupt vector priority block
package ivp_pkg;

  // ****************************************
  // Vector table geometry
  // ****************************************
  localparam int          NUM_VEC      = 83;
  localparam int          VEC_W        = 7;
  localparam int          FETCH_W      = 21;
  localparam int          BASE_W       = 13;
  localparam int          BASE_SHIFT   = 8;
  localparam int          LVL_REGS     = 6;
  localparam int          FLD_PER_REG  = 16;
  localparam logic [12:0] BASE_RST     = 13'h0000;
  localparam logic [12:0] OVERLAY_BASE = 13'h0200;

  // ****************************************
  // Internal priority ranks, higher wins
  // ****************************************
  localparam logic [2:0] RANK_NONE = 3'h0;
  localparam logic [2:0] RANK_LP   = 3'h1;
  localparam logic [2:0] RANK_L0   = 3'h2;
  localparam logic [2:0] RANK_L1   = 3'h3;
  localparam logic [2:0] RANK_L2   = 3'h4;
  localparam logic [2:0] RANK_L3   = 3'h5;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_BASE  = 8'h00;
  localparam logic [7:0] OFF_PEND0 = 8'h04;
  localparam logic [7:0] OFF_PEND1 = 8'h08;
  localparam logic [7:0] OFF_PEND2 = 8'h0c;
  localparam logic [7:0] OFF_WIN   = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;
  localparam logic [7:0] OFF_MASK  = 8'h18;
  localparam logic [7:0] OFF_LVL0  = 8'h20;
  localparam logic [7:0] OFF_LVL_E = 8'h38;

  // ****************************************
  // Status bit positions and reset values
  // ****************************************
  localparam int         STAT_W       = 2;
  localparam int         STAT_ACK     = 0;
  localparam int         STAT_TOP     = 1;
  localparam logic [1:0] MASK_RST     = 2'h0;

  typedef enum logic [2:0] {
    KIND_RSVD = 3'b000,
    KIND_L3   = 3'b001,
    KIND_L2   = 3'b010,
    KIND_L1   = 3'b011,
    KIND_L0   = 3'b100,
    KIND_LP   = 3'b101,
    KIND_P13  = 3'b110,
    KIND_P02  = 3'b111
  } ivp_kind_t;

  // Kind of each vector slot
  function automatic ivp_kind_t ivp_vec_kind(input int v);
    case (v)
      2, 3, 4, 5:          return KIND_L3;
      6, 7, 9, 10, 11:     return KIND_P13;
      14:                  return KIND_L2;
      15:                  return KIND_L1;
      16:                  return KIND_L0;
      81:                  return KIND_LP;
      17, 20, 21, 22, 23, 24, 26, 27, 28, 29, 33, 34, 35, 38, 39, 40,
      41, 42, 43, 45, 46, 49, 50, 56, 57, 58, 59, 64, 65, 66, 67, 68,
      69, 71, 72, 74, 76, 78, 80, 82:
                           return KIND_P02;
      default:             return KIND_RSVD;
    endcase
  endfunction : ivp_vec_kind

endpackage : ivp_pkg

/* bench/ivp_properties.sv */
// Checker of the vector outputs of the priority block
`timescale 1ns/1ps
module ivp_chk
  import ivp_pkg::*;
(
  // Clock and reset
  input wire logic                        i_ref_clk,
  input wire logic                        i_sys_rst,
  // Watched ports
  input wire logic                        i_psel,
  input wire logic                        i_penable,
  input wire logic                        o_pready,
  input wire logic [3:0]                  i_core_exc,
  input wire logic                        o_irq_valid,
  input wire logic [ivp_pkg::VEC_W-1:0]   o_irq_vector,
  input wire logic [2:0]                  o_irq_rank,
  input wire logic [ivp_pkg::FETCH_W-1:0] o_fetch_addr,
  input wire logic                        o_reset_overlay
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ****
  // Properties
  // ****
  chk_entry_offset: assert property (o_irq_valid |->
    o_fetch_addr[7:0] == {o_irq_vector, 1'b0}) else $error("bad offset");
  chk_overlay_base: assert property (o_reset_overlay && o_irq_valid |->
    o_fetch_addr[20:8] == 13'h0200) else $error("bad overlay base");
  chk_core_rank: assert property (o_irq_valid &&
    o_irq_vector inside {[2:5]} |-> o_irq_rank == 3'h5)
    else $error("core rank wrong");
  chk_core_win: assert property (i_core_exc[0] |=>
    o_irq_valid && o_irq_vector == 7'd2) else $error("core loses");
  chk_same_level: assert property (i_core_exc == 4'b1100 |=>
    o_irq_vector == 7'd4) else $error("wrong tie winner");
  chk_soft_rank: assert property (o_irq_valid &&
    o_irq_vector inside {14, 15, 16, 81} |-> ((o_irq_vector == 7'd81) ?
    o_irq_rank == 3'h1 : o_irq_rank == 3'(7'd18 - o_irq_vector)))
    else $error("soft rank wrong");
  chk_debug_range: assert property (o_irq_valid &&
    o_irq_vector inside {6, 7, 9, 10, 11} |-> o_irq_rank inside {[3:5]})
    else $error("debug rank out of range");
  chk_periph_range: assert property (o_irq_valid &&
    o_irq_vector >= 7'd17 && o_irq_vector != 7'd81 |->
    o_irq_rank inside {[2:4]}) else $error("peripheral rank wrong");
  chk_no_reserved: assert property (o_irq_valid |->
    o_irq_vector <= 7'd82 &&
    !(o_irq_vector inside {0, 1, 8, 12, 13, 18, 19, 25, [30:32], 36, 37,
    44, 47, 48, [51:55], [60:63], 70, 73, 75, 77, 79}))
    else $error("reserved vector shown");
  chk_valid_rank: assert property (o_irq_valid == (o_irq_rank != 3'h0))
    else $error("valid and rank disagree");
  chk_ready_slot: assert property (i_psel && !i_penable |->
    ##2 o_pready ##1 !o_pready) else $error("ready timing wrong");
endmodule : ivp_chk

bind ivp_top ivp_chk chk_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .i_core_exc(i_core_exc), .o_irq_valid(o_irq_valid),
  .o_irq_vector(o_irq_vector), .o_irq_rank(o_irq_rank),
  .o_fetch_addr(o_fetch_addr), .o_reset_overlay(o_reset_overlay));

/* bench/ivp_core_model.sv */
// Core side model that takes presented vectors
`timescale 1ns/1ps
module ivp_core_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // Vector presentation
  input  wire logic       i_irq_valid,
  input  wire logic [3:0] i_ack_dly,
  output logic            o_core_ack
);
  logic [3:0] wait_r;
  logic       done_r;
  // One take per presentation, after a set delay
  always_ff @(posedge i_ref_clk) begin
    o_core_ack <= 1'b0;
    if (i_sys_rst || !i_irq_valid) begin
      wait_r <= 4'h0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (wait_r == i_ack_dly) begin
        o_core_ack <= 1'b1;
        done_r     <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : ivp_core_model

/* bench/tb.sv */
// Self-checking bench of the interrupt vector priority block
`timescale 1ns/1ps
module tb;
  import ivp_pkg::*;
  logic        i_ref_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        err, ack, valid, overlay, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [82:0] rq;
  logic [6:0]  vec;
  logic [2:0]  rank;
  logic [20:0] fetch;
  logic [3:0]  dly;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  int vl[$] = '{2, 3, 4, 5, 6, 7, 9, 10, 11, 14, 15, 16, 17, 20, 21, 22, 23,
    24, 26, 27, 28, 29, 33, 34, 35, 38, 39, 40, 41, 42, 43, 45, 46, 49, 50,
    56, 57, 58, 59, 64, 65, 66, 67, 68, 69, 71, 72, 74, 76, 78, 80, 81, 82};

  // Reserved vectors have no source wired
  ivp_top dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_core_exc(rq[5:2]),
    .i_debug_req({rq[11:9], rq[7:6]}), .i_soft_irq({rq[81], rq[16:14]}),
    .i_external_interrupt_request(rq[17]),
    .i_supply_voltage_monitor(rq[20]), .i_clock_synth(rq[21]),
    .i_flash_controller(rq[24:22]), .i_can_unit(rq[29:26]),
    .i_port_three_pins(rq[33]), .i_port_two_pins(rq[34]),
    .i_port_one_pins(rq[35]), .i_second_spi_unit(rq[39:38]),
    .i_first_spi_unit(rq[41:40]),
    .i_second_serial_unit({rq[46:45], rq[43:42]}),
    .i_first_serial_unit({rq[72:71], rq[69:68]}),
    .i_quadrature_decoder(rq[50:49]), .i_timer_group_two(rq[59:56]),
    .i_timer_group_one(rq[67:64]), .i_converter_unit({rq[76], rq[74]}),
    .i_pwm_unit({rq[80], rq[78]}), .i_spare_req(rq[82]), .i_core_ack(ack),
    .o_irq_valid(valid), .o_irq_vector(vec), .o_irq_rank(rank),
    .o_fetch_addr(fetch), .o_reset_overlay(overlay), .o_int(irq));

  ivp_core_model core_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_irq_valid(valid), .i_ack_dly(dly), .o_core_ack(ack));

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc

  task automatic req(input logic [82:0] r);
    rq <= r;
    repeat (2) @(posedge i_ref_clk);
  endtask : req

  // Rank with every level field at one
  function automatic logic [2:0] er(input int v);
    if (v <= 5) return 3'h5;
    if (v inside {6, 7, 9, 10, 11, 15}) return 3'h3;
    if (v == 14) return 3'h4;
    if (v == 81) return 3'h1;
    return 3'h2;
  endfunction : er

  initial begin
    i_sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, rq, dly} = '0;
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    rdc(OFF_BASE, 32'h0, "base");
    rdc(OFF_MASK, 32'h0, "mask");
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", err, 32'h1);
    req(83'h1 << 20);
    chk("disabled", valid, 32'h0);
    rdc(OFF_PEND0, 32'h0, "not pending");
    for (int i = 0; i < 6; i++) apb(1'b1, OFF_LVL0 + 8'(4 * i), 32'h5555_5555);
    // Overlay on; entries 0 and 1 keep the reset jumps, never requested
    apb(1'b1, OFF_BASE, 32'h200);
    foreach (vl[i]) begin
      req(83'h1 << vl[i]);
      chk("vector", vec, vl[i]);
      chk("rank", rank, er(vl[i]));
      chk("fetch", fetch, 21'h20000 + 21'(2 * vl[i]));
      chk("overlay", overlay, 32'h1);
    end
    apb(1'b1, OFF_BASE, 32'h11);
    req(83'h1 << 22);
    chk("base fetch", fetch, 32'h112c);
    chk("overlay off", overlay, 32'h0);
    req((83'h1 << 16) | (83'h1 << 17));
    chk("same level", vec, 32'd16);
    rdc(OFF_PEND0, 32'h0003_0000, "pending");
    rdc(OFF_WIN, 32'h0000_0510, "winner");
    apb(1'b1, OFF_LVL0 + 8'h08, 32'h5555_555d);
    req((83'h1 << 20) | (83'h1 << 33) | (83'h1 << 7));
    chk("level win", vec, 32'd33);
    for (int l = 1; l < 4; l++) begin
      apb(1'b1, OFF_LVL0, 32'h5555_1555 | (32'(l) << 14));
      req(83'h1 << 7);
      chk("debug rank", rank, 32'(l + 2));
    end
    rdc(OFF_LVL0, 32'h0054_d000, "level fields");
    req((83'h1 << 7) | (83'h1 << 5));
    chk("core tie", vec, 32'd5);
    req((83'h1 << 4) | (83'h1 << 5));
    chk("core pair", vec, 32'd4);
    // ****
    // Status, mask and interrupt line
    // ****
    req(83'h0);
    apb(1'b1, OFF_STAT, 32'h3);
    apb(1'b1, OFF_MASK, 32'h2);
    dly <= 4'h6;
    req(83'h1 << 3);
    repeat (3) @(posedge i_ref_clk);
    chk("int on", irq, 32'h1);
    repeat (10) @(posedge i_ref_clk);
    rdc(OFF_STAT, 32'h3, "status set");
    apb(1'b1, OFF_MASK, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    chk("int masked", irq, 32'h0);
    req(83'h0);
    apb(1'b1, OFF_STAT, 32'h3);
    rdc(OFF_STAT, 32'h0, "status clear");
    close_out();
  end
endmodule : tb
